// ---- rtl/sfr_pkg.sv ----
package sfr_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_PIN_BASE = 8'h00;
    localparam logic [7:0] OFS_PORT_STRIDE = 8'h08;
    localparam logic [7:0] OFS_DIR_DELTA = 8'h04;
    localparam logic [7:0] OFS_OUTB = 8'h20;
    localparam logic [7:0] OFS_BPTR = 8'h24;
    localparam logic [7:0] OFS_BAT = 8'h28;
    localparam logic [7:0] OFS_BINC = 8'h2C;
    localparam logic [7:0] OFS_BDEC = 8'h30;
    localparam logic [7:0] OFS_PTRL = 8'h34;
    localparam logic [7:0] OFS_PTRH = 8'h38;
    localparam logic [7:0] OFS_PAT = 8'h3C;
    localparam logic [7:0] OFS_PINC = 8'h40;
    localparam logic [7:0] OFS_PDEC = 8'h44;
    localparam logic [7:0] OFS_FLAGS = 8'h48;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h4C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h50;
    localparam logic [7:0] OFS_BITOP = 8'h54;
    localparam logic [7:0] OFS_HW_EN = 8'h58;

    // Ports and implemented pin positions, index 0 is port A
    localparam int NPORT = 4;
    localparam logic [3:0][7:0] PORT_IN_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [3:0][7:0] PORT_OUT_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam int PORT_B = 1;

    // Scratchpad pointer widths
    localparam int BSCR_AW = 8;
    localparam int MSCR_AW = 10;
    localparam int PTRH_BITS = MSCR_AW - 8;

    // Pointer step codes
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;

    // System flag bit positions
    localparam int FLG_INTERRUPT_PIN_ZERO = 0;
    localparam int FLG_ANY = 3;
    localparam int FLG_COMP = 4;
    localparam int FLG_RX = 5;
    localparam int FLG_I2C = 6;
    localparam int FLG_TMR = 7;

    // Bit operation register fields
    localparam int BOP_BIT_LSB = 0;
    localparam int BOP_PORT_LSB = 3;
    localparam int BOP_TGT_LSB = 5;
    localparam int BOP_VAL = 7;
    localparam logic [1:0] TGT_LATCH = 2'h0;
    localparam logic [1:0] TGT_DIR = 2'h1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_HW_EN = 8'hFF;
    localparam logic [7:0] RST_OE_B = 8'hFF;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Bus slave states, Gray coded along the path
    typedef enum logic [1:0] {
        SFR_IDLE = 2'b00,
        SFR_ACCESS = 2'b01,
        SFR_DONE = 2'b11
    } sfr_state_e;
endpackage : sfr_pkg

// ---- rtl/sfr_port.sv ----
`timescale 1ns/100ps
module sfr_port
    import sfr_pkg::*;
#(
    parameter logic [7:0] IN_MASK = 8'hFF,
    parameter logic [7:0] OUT_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] pin_in,
    input wire logic latch_wr,
    input wire logic [7:0] latch_wdata,
    input wire logic dir_wr,
    input wire logic [7:0] dir_wdata,
    output logic [7:0] pin_q,
    output logic [7:0] latch_q,
    output logic [7:0] dir_q,
    output logic [7:0] pad_oe_b
);
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;

    // Two-stage synchroniser on the pads
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= RST_BYTE;
            sync2_r <= RST_BYTE;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end
    assign pin_q = sync2_r & IN_MASK;

    // Output latch keeps only real output positions
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= RST_BYTE;
        end else if (latch_wr) begin
            latch_q <= latch_wdata & OUT_MASK;
        end
    end

    // Direction, 1 means output; enable is active low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_q <= RST_BYTE;
            pad_oe_b <= RST_OE_B;
        end else if (dir_wr) begin
            dir_q <= dir_wdata;
            pad_oe_b <= ~(dir_wdata & OUT_MASK);
        end
    end
endmodule : sfr_port

// ---- rtl/sfr_scratch.sv ----
`timescale 1ns/100ps
module sfr_scratch
    import sfr_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ptr_wr,
    input wire logic [AW-1:0] ptr_wdata,
    input wire logic acc_en,
    input wire logic acc_wr,
    input wire logic [7:0] acc_wdata,
    input wire logic [1:0] acc_step,
    output logic [AW-1:0] ptr_q,
    output logic [7:0] acc_rdata
);
    logic [7:0] mem_r [0:(1<<AW)-1];

    // Scratchpad array, addressed by the pointer
    always_ff @(posedge clk) begin
        if (acc_en && acc_wr) begin
            mem_r[ptr_q] <= acc_wdata;
        end
    end
    assign acc_rdata = mem_r[ptr_q];

    // Pointer moves after the access; wraps at its width
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= '0;
        end else if (ptr_wr) begin
            ptr_q <= ptr_wdata;
        end else if (acc_en && acc_step == STEP_INC) begin
            ptr_q <= ptr_q + 1'b1;
        end else if (acc_en && acc_step == STEP_DEC) begin
            ptr_q <= ptr_q - 1'b1;
        end
    end
endmodule : sfr_scratch

// ---- rtl/sfr_top.sv ----
// Function
// - Writing a port's pin byte loads that port's output latch with the written value.
// - Reading a port's pin byte returns the synchronised input pins, not the latch.
// - Each input bit can be read on its own, and unimplemented input positions read zero.
// - Each latch bit can be written alone without touching the others, only at real outputs.
// - Ports A to D each have an 8-bit direction register whose bits can be set one by one.
// - An 8-bit byte pointer, bit-accessible, addresses the byte scratchpad indirectly; here the bit operation reaches only port latch, direction and pin bits.
// - Byte pointer access has plain, post-increment and post-decrement forms, stepping after.
// - The main pointer is 10 bits, low byte bits 7..0, high byte bits 9..8 with the rest zero.
// - Main pointer access has plain, post-increment and post-decrement forms, stepping after.
// - Flag bits 0..2 are set by interrupt pins zero to two, bit 3 by any of them.
// - Flag bits 4..7 are set by comparator, serial receive, I2C slave write and timer overflow.
// - A flag whose hardware source is unused stays a free software read/write bit.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module sfr_top
    import sfr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [7:0] port_d_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_b_out,
    output logic [7:0] port_c_out,
    output logic [7:0] port_d_out,
    output logic [7:0] port_a_oe_b,
    output logic [7:0] port_b_oe_b,
    output logic [7:0] port_c_oe_b,
    output logic [7:0] port_d_oe_b,
    input wire logic interrupt_pin_zero,
    input wire logic interrupt_pin_one,
    input wire logic interrupt_pin_two,
    input wire logic comp_event,
    input wire logic serial_rx_event,
    input wire logic i2c_slave_write_event,
    input wire logic timer_ovf_event,
    output logic irq
);
    sfr_state_e state_r;
    logic [7:0] addr_r;
    logic write_r;
    logic acc;
    logic wr;
    logic [7:0] wd;
    logic [7:0] rd_val;
    logic [NPORT-1:0][7:0] pin_in_w;
    logic [NPORT-1:0][7:0] pin_q;
    logic [NPORT-1:0][7:0] latch_q;
    logic [NPORT-1:0][7:0] dir_q;
    logic [NPORT-1:0][7:0] oe_b_q;
    logic [7:0] bitop_r;
    logic [1:0] bop_tgt;
    logic [1:0] bop_port;
    logic [2:0] bop_bit;
    logic [1:0] wd_tgt;
    logic [1:0] wd_port;
    logic [2:0] wd_bit;
    logic bop_wr;
    logic [7:0] bptr_q;
    logic [7:0] bscr_rdata;
    logic bscr_hit;
    logic [1:0] bscr_step;
    logic [MSCR_AW-1:0] ptr_q;
    logic [MSCR_AW-1:0] ptr_wdata;
    logic [7:0] mscr_rdata;
    logic mscr_hit;
    logic [1:0] mscr_step;
    logic [2:0] int_s1_r;
    logic [2:0] int_s2_r;
    logic [2:0] int_s3_r;
    logic [2:0] int_rise;
    logic [7:0] hw_event;
    logic [7:0] flags_r;
    logic [7:0] hw_en_r;
    logic [7:0] irq_stat_r;
    logic [7:0] irq_mask_r;

    // AHB-Lite slave: one wait state, then the access is done
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SFR_IDLE;
            addr_r <= RST_BYTE;
            write_r <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            case (state_r)
                SFR_IDLE, SFR_DONE: begin
                    if (hsel && htrans[1] && hready) begin
                        state_r <= SFR_ACCESS;
                        addr_r <= haddr[7:0];
                        write_r <= hwrite;
                        hreadyout <= 1'b0;
                    end else begin
                        state_r <= SFR_IDLE;
                        hreadyout <= 1'b1;
                    end
                end
                SFR_ACCESS: begin
                    state_r <= SFR_DONE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    state_r <= SFR_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Response is always OKAY
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    assign acc = (state_r == SFR_ACCESS);
    assign wr = acc && write_r;
    assign wd = hwdata[7:0];

    // Bit operation fields, from the write data and the stored select
    assign wd_bit = wd[BOP_BIT_LSB +: 3];
    assign wd_port = wd[BOP_PORT_LSB +: 2];
    assign wd_tgt = wd[BOP_TGT_LSB +: 2];
    assign bop_bit = bitop_r[BOP_BIT_LSB +: 3];
    assign bop_port = bitop_r[BOP_PORT_LSB +: 2];
    assign bop_tgt = bitop_r[BOP_TGT_LSB +: 2];
    assign bop_wr = wr && (addr_r == OFS_BITOP);

    // Bit select register remembers the last bit operation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitop_r <= RST_BYTE;
        end else if (bop_wr) begin
            bitop_r <= wd;
        end
    end

    assign pin_in_w[0] = port_a_in;
    assign pin_in_w[1] = port_b_in;
    assign pin_in_w[2] = port_c_in;
    assign pin_in_w[3] = port_d_in;

    // One port block per port with byte and single-bit writes
    generate
        for (genvar p = 0; p < NPORT; p++) begin : g_port
            logic pin_hit;
            logic dir_hit;
            logic bit_latch;
            logic bit_dir;
            logic [7:0] bit_one;
            logic [7:0] latch_wd;
            logic [7:0] dir_wd;

            assign pin_hit = (addr_r == 8'(OFS_PIN_BASE + p * OFS_PORT_STRIDE));
            assign dir_hit = (addr_r == 8'(OFS_PIN_BASE + p * OFS_PORT_STRIDE + OFS_DIR_DELTA));
            assign bit_one = 8'h01 << wd_bit;
            assign bit_latch = bop_wr && wd_port == 2'(p) && wd_tgt == TGT_LATCH;
            assign bit_dir = bop_wr && wd_port == 2'(p) && wd_tgt == TGT_DIR;
            // Single-bit write changes only the addressed bit
            assign latch_wd = bit_latch ? (wd[BOP_VAL] ? (latch_q[p] | bit_one) :
                                           (latch_q[p] & ~bit_one)) : wd;
            assign dir_wd = bit_dir ? (wd[BOP_VAL] ? (dir_q[p] | bit_one) :
                                       (dir_q[p] & ~bit_one)) : wd;

            sfr_port #(
                .IN_MASK(PORT_IN_MASK[p]),
                .OUT_MASK(PORT_OUT_MASK[p])
            ) u_port (
                .clk(clk),
                .rst_b(rst_b),
                .pin_in(pin_in_w[p]),
                .latch_wr((wr && pin_hit) || bit_latch ||
                          (p == PORT_B && wr && addr_r == OFS_OUTB)),
                .latch_wdata(latch_wd),
                .dir_wr((wr && dir_hit) || bit_dir),
                .dir_wdata(dir_wd),
                .pin_q(pin_q[p]),
                .latch_q(latch_q[p]),
                .dir_q(dir_q[p]),
                .pad_oe_b(oe_b_q[p])
            );
        end
    endgenerate

    assign port_a_out = latch_q[0];
    assign port_b_out = latch_q[1];
    assign port_c_out = latch_q[2];
    assign port_d_out = latch_q[3];
    assign port_a_oe_b = oe_b_q[0];
    assign port_b_oe_b = oe_b_q[1];
    assign port_c_oe_b = oe_b_q[2];
    assign port_d_oe_b = oe_b_q[3];

    // Byte scratchpad: plain, post-increment, post-decrement windows
    assign bscr_hit = acc && (addr_r == OFS_BAT || addr_r == OFS_BINC || addr_r == OFS_BDEC);
    assign bscr_step = (addr_r == OFS_BINC) ? STEP_INC :
                       (addr_r == OFS_BDEC) ? STEP_DEC : STEP_NONE;

    sfr_scratch #(
        .AW(BSCR_AW)
    ) u_bscr (
        .clk(clk),
        .rst_b(rst_b),
        .ptr_wr(wr && addr_r == OFS_BPTR),
        .ptr_wdata(wd),
        .acc_en(bscr_hit),
        .acc_wr(write_r),
        .acc_wdata(wd),
        .acc_step(bscr_step),
        .ptr_q(bptr_q),
        .acc_rdata(bscr_rdata)
    );

    // Main scratchpad: pointer written a byte at a time
    assign mscr_hit = acc && (addr_r == OFS_PAT || addr_r == OFS_PINC || addr_r == OFS_PDEC);
    assign mscr_step = (addr_r == OFS_PINC) ? STEP_INC :
                       (addr_r == OFS_PDEC) ? STEP_DEC : STEP_NONE;
    assign ptr_wdata = (addr_r == OFS_PTRH) ? {wd[PTRH_BITS-1:0], ptr_q[7:0]} :
                       {ptr_q[MSCR_AW-1:8], wd};

    sfr_scratch #(
        .AW(MSCR_AW)
    ) u_mscr (
        .clk(clk),
        .rst_b(rst_b),
        .ptr_wr(wr && (addr_r == OFS_PTRL || addr_r == OFS_PTRH)),
        .ptr_wdata(ptr_wdata),
        .acc_en(mscr_hit),
        .acc_wr(write_r),
        .acc_wdata(wd),
        .acc_step(mscr_step),
        .ptr_q(ptr_q),
        .acc_rdata(mscr_rdata)
    );

    // Interrupt pins: two-stage synchroniser, then rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_s1_r <= 3'h0;
            int_s2_r <= 3'h0;
            int_s3_r <= 3'h0;
        end else begin
            int_s1_r <= {interrupt_pin_two, interrupt_pin_one, interrupt_pin_zero};
            int_s2_r <= int_s1_r;
            int_s3_r <= int_s2_r;
        end
    end
    assign int_rise = int_s2_r & ~int_s3_r;

    // Hardware events in flag layout
    assign hw_event[FLG_INTERRUPT_PIN_ZERO +: 3] = int_rise;
    assign hw_event[FLG_ANY] = |int_rise;
    assign hw_event[FLG_COMP] = comp_event;
    assign hw_event[FLG_RX] = serial_rx_event;
    assign hw_event[FLG_I2C] = i2c_slave_write_event;
    assign hw_event[FLG_TMR] = timer_ovf_event;

    // Source enables; a disabled source leaves its flag to software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hw_en_r <= RST_HW_EN;
        end else if (wr && addr_r == OFS_HW_EN) begin
            hw_en_r <= wd;
        end
    end

    // System flags: software writes, enabled hardware events set (set wins)
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= RST_BYTE;
        end else if (wr && addr_r == OFS_FLAGS) begin
            flags_r <= wd | (hw_event & hw_en_r);
        end else begin
            flags_r <= flags_r | (hw_event & hw_en_r);
        end
    end

    // Sticky interrupt status, write one to clear, event wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= RST_BYTE;
        end else if (wr && addr_r == OFS_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~wd) | hw_event;
        end else begin
            irq_stat_r <= irq_stat_r | hw_event;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_r <= RST_BYTE;
        end else if (wr && addr_r == OFS_IRQ_MASK) begin
            irq_mask_r <= wd;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read multiplexer; unmapped and write-only read zero
    always_comb begin
        rd_val = RST_BYTE;
        for (int p = 0; p < NPORT; p++) begin
            if (addr_r == 8'(OFS_PIN_BASE + p * OFS_PORT_STRIDE)) begin
                rd_val = pin_q[p];
            end
            if (addr_r == 8'(OFS_PIN_BASE + p * OFS_PORT_STRIDE + OFS_DIR_DELTA)) begin
                rd_val = dir_q[p];
            end
        end
        case (addr_r)
            OFS_BPTR: rd_val = bptr_q;
            OFS_BAT, OFS_BINC, OFS_BDEC: rd_val = bscr_rdata;
            OFS_PTRL: rd_val = ptr_q[7:0];
            OFS_PTRH: rd_val = {{(8-PTRH_BITS){1'b0}}, ptr_q[MSCR_AW-1:8]};
            OFS_PAT, OFS_PINC, OFS_PDEC: rd_val = mscr_rdata;
            OFS_FLAGS: rd_val = flags_r;
            OFS_IRQ_STAT: rd_val = irq_stat_r;
            OFS_IRQ_MASK: rd_val = irq_mask_r;
            OFS_HW_EN: rd_val = hw_en_r;
            OFS_BITOP: begin
                rd_val = {bitop_r[6:0], 1'b0};
                case (bop_tgt)
                    TGT_LATCH: rd_val[0] = latch_q[bop_port][bop_bit];
                    TGT_DIR: rd_val[0] = dir_q[bop_port][bop_bit];
                    default: rd_val[0] = pin_q[bop_port][bop_bit];
                endcase
            end
            default: begin
            end
        endcase
    end

    // Read data captured at the end of the wait state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= RST_WORD;
        end else if (acc && !write_r) begin
            hrdata <= {24'h000000, rd_val};
        end
    end
endmodule : sfr_top

// ---- verif/sfr_top_properties.sv ----
`timescale 1ns/100ps
module sfr_top_properties
    import sfr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_out,
    input wire logic irq
);
    logic tk;
    // Address phase accepted by the slave
    assign tk = hsel && htrans[1] && hready && hreadyout;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_one_wait_state: assert property (tk |=> !hreadyout ##1 hreadyout)
        else $error("wait state length wrong");
    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_upper_data_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_pin_write_latch: assert property (
        tk && hwrite && haddr[7:0] == OFS_PORT_STRIDE |=> ##1 port_b_out == $past(hwdata[7:0]))
        else $error("pin byte write did not load latch");
    a_latch_only_write: assert property (!$stable(port_b_out) |-> !$past(hreadyout))
        else $error("latch changed outside a write");
    a_pin_read_input: assert property (
        tk && !hwrite && haddr[7:0] == OFS_PIN_BASE && port_a_in == $past(port_a_in)
        && port_a_in == $past(port_a_in, 2) && port_a_in == $past(port_a_in, 3)
        |=> ##1 hrdata[7:0] == $past(port_a_in, 2))
        else $error("pin read not input state");
    a_ptrh_upper_zero: assert property (
        tk && !hwrite && haddr[7:0] == OFS_PTRH |=> ##1 hrdata[7:2] == 6'h00)
        else $error("pointer high unused bits set");
    a_unmapped_zero: assert property (
        tk && !hwrite && haddr[7:0] > OFS_HW_EN |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    c_write: cover property (tk && hwrite);
    c_read: cover property (tk && !hwrite);
    c_irq: cover property ($rose(irq));
endmodule : sfr_top_properties

bind sfr_top sfr_top_properties i_sfr_top_properties (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .port_a_in, .port_b_out, .irq);

// ---- verif/sfr_pin_model.sv ----
`timescale 1ns/100ps
module sfr_pin_model
    import sfr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0][7:0] pad_out,
    input wire logic [3:0][7:0] pad_oe_b,
    input wire logic [3:0][7:0] ext,
    input wire logic [6:0] ev_cmd,
    output logic [3:0][7:0] pad_in,
    output logic [2:0] int_pin,
    output logic [3:0] ev_pulse
);
    logic [3:0] ev_r;
    // Pad shows the latch where driven, the outside level elsewhere
    assign pad_in = (pad_out & ~pad_oe_b) | (ext & pad_oe_b);
    // Interrupt pins follow the command levels
    assign int_pin = ev_cmd[2:0];
    // On-chip sources give one pulse per rising command edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_r <= 4'h0;
            ev_pulse <= 4'h0;
        end else begin
            ev_r <= ev_cmd[6:3];
            ev_pulse <= ev_cmd[6:3] & ~ev_r;
        end
    end
endmodule : sfr_pin_model

// ---- verif/special_function_register_set_bench.sv ----
`timescale 1ns/100ps
module special_function_register_set_bench
    import sfr_pkg::*;
;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, rd_ph;
    logic [1:0] htrans;
    logic [2:0] hsize, b;
    logic [31:0] haddr, hwdata, hrdata;
    logic [3:0][7:0] pin, pout, poe_b, ext, lat, dir;
    logic [2:0] ipin;
    logic [3:0] evp;
    logic [6:0] ev_cmd;
    logic [7:0] v, x, pa, w;
    logic [15:0] lfsr;
    logic [31:0] expq[$];
    int n_fail, compares;
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sfr_top i_sfr_top (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .port_a_in(pin[0]), .port_b_in(pin[1]), .port_c_in(pin[2]),
        .port_d_in(pin[3]), .port_a_out(pout[0]), .port_b_out(pout[1]), .port_c_out(pout[2]),
        .port_d_out(pout[3]), .port_a_oe_b(poe_b[0]), .port_b_oe_b(poe_b[1]),
        .port_c_oe_b(poe_b[2]), .port_d_oe_b(poe_b[3]), .interrupt_pin_zero(ipin[0]),
        .interrupt_pin_one(ipin[1]), .interrupt_pin_two(ipin[2]), .comp_event(evp[0]),
        .serial_rx_event(evp[1]), .i2c_slave_write_event(evp[2]), .timer_ovf_event(evp[3]), .irq(irq));
    sfr_pin_model i_sfr_pin_model (.clk(clk), .rst_b(rst_b), .pad_out(pout), .pad_oe_b(poe_b),
        .ext(ext), .ev_cmd(ev_cmd), .pad_in(pin), .int_pin(ipin), .ev_pulse(evp));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One single transfer; read expectations go to the queue
    task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr_n;
        do @(posedge clk); while (hreadyout !== 1'b1);
        if (!wr_n) expq.push_back(e);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !wr_n;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0, {24'h0, e});
    endtask : rd
    // Raise a source command for a while, then drop it
    task automatic fire(input int k);
        ev_cmd <= 7'h01 << k;
        repeat (5) @(posedge clk);
        ev_cmd <= 7'h00;
        repeat (2) @(posedge clk);
    endtask : fire
    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Read data monitor takes the oldest expectation
    always @(posedge clk) begin
        if (rd_ph && hreadyout === 1'b1) check(hrdata, expq.pop_front());
    end
    // Watchdog
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        {rst_b, hwrite, rd_ph, haddr, hwdata, htrans, ext, ev_cmd} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        n_fail = 0;
        compares = 0;
        lfsr = 16'hC8A6;
        repeat (5) @(posedge clk);
        check(poe_b, 32'hFFFF_FFFF);
        check(pout, 32'h0);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFS_FLAGS, 8'h00);
        rd(8'h7C, 8'h00);
        for (int p = 0; p < NPORT; p++) begin
            pa = OFS_PIN_BASE + 8'(p) * OFS_PORT_STRIDE;
            lat[p] = rnd();
            dir[p] = rnd();
            x = rnd();
            ext[p] <= x;
            wr(pa, lat[p]);
            wr(pa + OFS_DIR_DELTA, dir[p]);
            repeat (3) @(posedge clk);
            rd(pa + OFS_DIR_DELTA, dir[p]);
            rd(pa, (lat[p] & dir[p]) | (x & ~dir[p]));
            check({24'h0, pout[p]}, {24'h0, lat[p]});
            check({24'h0, poe_b[p]}, {24'h0, ~dir[p]});
        end
        wr(OFS_PORT_STRIDE, 8'hC0);
        lat[1] = 8'hC0;
        check({24'h0, pout[1]}, 32'hC0);
        wr(OFS_OUTB, 8'h3C);
        lat[1] = 8'h3C;
        rd(OFS_OUTB, 8'h00);
        check({24'h0, pout[1]}, 32'h3C);
        for (int i = 0; i < 8; i++) begin
            b = 3'(i);
            v = rnd();
            w = {v[7], i[0] ? TGT_DIR : TGT_LATCH, 2'(i % 4), b};
            wr(OFS_BITOP, w);
            if (i[0]) dir[i % 4][b] = v[7];
            else lat[i % 4][b] = v[7];
            repeat (3) @(posedge clk);
            check({24'h0, pout[i % 4]}, {24'h0, lat[i % 4]});
            check({24'h0, poe_b[i % 4]}, {24'h0, ~dir[i % 4]});
            w = {3'h2, 2'(i % 4), b};
            wr(OFS_BITOP, w);
            rd(OFS_BITOP, {w[6:0], dir[i % 4][b] ? lat[i % 4][b] : ext[i % 4][b]});
        end
        // Byte pointer steps after access and wraps
        wr(OFS_BPTR, 8'hFF);
        wr(OFS_BINC, 8'hA5);
        rd(OFS_BPTR, 8'h00);
        wr(OFS_BDEC, 8'h3C);
        rd(OFS_BPTR, 8'hFF);
        rd(OFS_BDEC, 8'hA5);
        rd(OFS_BPTR, 8'hFE);
        wr(OFS_BAT, 8'h77);
        rd(OFS_BPTR, 8'hFE);
        rd(OFS_BINC, 8'h77);
        rd(OFS_BINC, 8'hA5);
        rd(OFS_BAT, 8'h3C);
        // Ten-bit pointer across the wrap
        wr(OFS_PTRL, 8'hFF);
        wr(OFS_PTRH, 8'hFF);
        rd(OFS_PTRH, 8'h03);
        wr(OFS_PINC, 8'hC3);
        rd(OFS_PTRL, 8'h00);
        rd(OFS_PTRH, 8'h00);
        wr(OFS_PDEC, 8'h96);
        rd(OFS_PTRH, 8'h03);
        rd(OFS_PDEC, 8'hC3);
        rd(OFS_PTRL, 8'hFE);
        wr(OFS_PTRL, 8'hFF);
        rd(OFS_PAT, 8'hC3);
        // Each event source sets its own flag
        for (int k = 0; k < 7; k++) begin
            wr(OFS_FLAGS, 8'h00);
            fire(k);
            v = (k < 3) ? (8'h01 << k) | 8'h08 : 8'h01 << (k + 1);
            rd(OFS_FLAGS, v);
            rd(OFS_IRQ_STAT, v);
            wr(OFS_IRQ_STAT, 8'hFF);
            check({31'h0, irq}, 32'h0);
        end
        // Interrupt raised, masked and cleared
        wr(OFS_IRQ_MASK, 8'h01);
        fire(0);
        check({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_MASK, 8'h00);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 8'h01);
        @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 8'h01);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        // Unused source leaves a plain user bit
        wr(OFS_HW_EN, 8'h7F);
        wr(OFS_FLAGS, 8'h00);
        fire(6);
        rd(OFS_FLAGS, 8'h00);
        wr(OFS_FLAGS, 8'h80);
        rd(OFS_FLAGS, 8'h80);
        report_and_stop();
    end
endmodule : special_function_register_set_bench
